// ---- hdl/page_status_pkg.sv ----
// Constants for the register page control and live status bank
package page_status_pkg;
    localparam logic [8:0] ADDR_PAGE_CONTROL_0 = 9'h000;
    localparam logic [8:0] ADDR_PAGE_CONTROL_1 = 9'h080;
    localparam logic [8:0] ADDR_STATUS_MISC    = 9'h001;
    localparam logic [8:0] ADDR_STATUS_LOW     = 9'h002;
    localparam logic [8:0] ADDR_STATUS_HIGH    = 9'h003;
    localparam logic [8:0] ADDR_STATUS_LIMITS  = 9'h004;
    localparam logic [8:0] PAGE0_FIRST         = 9'h001;
    localparam logic [8:0] PAGE0_LAST          = 9'h03F;
    localparam logic [8:0] PAGE1_FIRST         = 9'h081;
    localparam logic [8:0] PAGE1_LAST          = 9'h0CF;
    localparam logic [8:0] PAGE2_FIRST         = 9'h101;
    localparam logic [8:0] PAGE2_LAST          = 9'h13F;
    localparam int AUTO_RETURN_BIT = 7;
    localparam int WRITE_MODE_BIT  = 6;
    localparam logic [7:0] PAGE_CONTROL_MASK  = 8'hC7;
    localparam logic [7:0] PAGE_CONTROL_RESET = 8'h00;
    localparam logic [2:0] PAGE_0    = 3'h0;
    localparam logic [2:0] PAGE_1    = 3'h1;
    localparam logic [2:0] PAGE_2    = 3'h2;
    localparam logic [2:0] PAGE_TEST = 3'h3;
endpackage : page_status_pkg

// ---- hdl/page_status_bank.sv ----
// Page control register and live status readback bank
//
// Contract
// - Auto-return bit clears page at each acc_done pulse unless page control is written in that cycle
// - Bit 6 selects page or repeated write
// - Page field maps offsets to three windows
// - Page control at offsets 0x00 and 0x80
// - Control interface owns its own page copy
// - Status reads are live, same polarity except misc bit 0
// - Misc status: comparator, ramping, wake pin
// - Bit 0 set while power key low
// - Low inputs status shows inputs or ADC
// - ADC indicator reads 1 above limit
// - Limits status shows four regulator overcurrents
`timescale 1ns/1ns
module page_status_bank
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Access port from the control interface, one pulse per byte
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_offset,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic        acc_done,
    output logic      [7:0]  acc_rdata,
    output logic             acc_hit,
    output logic      [8:0]  acc_addr,
    // Page control state seen by the interface
    output logic      [2:0]  page_select,
    output logic             repeated_write_mode,
    // Monitored pins
    input  wire logic        comparator_1v2_out,
    input  wire logic        voltage_ramp_active,
    input  wire logic        charger_wake_pin,
    input  wire logic        power_key_n,
    input  wire logic [15:0] general_input,
    input  wire logic [2:0]  adc_mode,
    input  wire logic [2:0]  adc_above_high,
    input  wire logic        reg11_overcurrent,
    input  wire logic        reg8_overcurrent,
    input  wire logic        reg7_overcurrent,
    input  wire logic        reg3_overcurrent
);
    logic [7:0]  page_control_reg;

    // Synchroniser stages per pin group
    logic [3:0]  misc_sync1_reg;
    logic [3:0]  misc_sync2_reg;
    logic [15:0] gpi_sync1_reg;
    logic [15:0] gpi_sync2_reg;
    logic [2:0]  adc_mode_sync1_reg;
    logic [2:0]  adc_mode_sync2_reg;
    logic [2:0]  adc_high_sync1_reg;
    logic [2:0]  adc_high_sync2_reg;
    logic [3:0]  limit_sync1_reg;
    logic [3:0]  limit_sync2_reg;

    logic [7:0]  misc_now;
    logic [7:0]  low_now;
    logic [7:0]  high_now;
    logic [7:0]  limit_now;
    logic [8:0]  addr_next;
    logic        is_page_control;
    logic        hit_next;
    logic [7:0]  rdata_next;

    // Two-flop synchronisers for all pin levels
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            misc_sync1_reg     <= 4'h1; // Key idles released
            misc_sync2_reg     <= 4'h1;
            gpi_sync1_reg      <= 16'h0000;
            gpi_sync2_reg      <= 16'h0000;
            adc_mode_sync1_reg <= 3'h0;
            adc_mode_sync2_reg <= 3'h0;
            adc_high_sync1_reg <= 3'h0;
            adc_high_sync2_reg <= 3'h0;
            limit_sync1_reg    <= 4'h0;
            limit_sync2_reg    <= 4'h0;
        end
        else
        begin
            misc_sync1_reg     <= {comparator_1v2_out, voltage_ramp_active,
                                   charger_wake_pin, power_key_n};
            misc_sync2_reg     <= misc_sync1_reg;
            gpi_sync1_reg      <= general_input;
            gpi_sync2_reg      <= gpi_sync1_reg;
            adc_mode_sync1_reg <= adc_mode;
            adc_mode_sync2_reg <= adc_mode_sync1_reg;
            adc_high_sync1_reg <= adc_above_high;
            adc_high_sync2_reg <= adc_high_sync1_reg;
            limit_sync1_reg    <= {reg11_overcurrent, reg8_overcurrent,
                                   reg7_overcurrent, reg3_overcurrent};
            limit_sync2_reg    <= limit_sync1_reg;
        end
    end

    // Live status images
    assign misc_now[7:4] = 4'h0;
    assign misc_now[3]   = misc_sync2_reg[3];
    assign misc_now[2]   = misc_sync2_reg[2];
    assign misc_now[1]   = misc_sync2_reg[1];
    assign misc_now[0]   = ~misc_sync2_reg[0];

    // Low inputs byte, ADC indicators may take bits 2:0
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : gen_low
            if (g < 3)
            begin : gen_adc
                assign low_now[g] = adc_mode_sync2_reg[g] ? adc_high_sync2_reg[g]
                                                          : gpi_sync2_reg[g];
            end
            else
            begin : gen_gpi
                assign low_now[g] = gpi_sync2_reg[g];
            end
        end
    endgenerate

    assign high_now       = gpi_sync2_reg[15:8];
    assign limit_now[7]   = limit_sync2_reg[3];
    assign limit_now[6]   = limit_sync2_reg[2];
    assign limit_now[5]   = limit_sync2_reg[1];
    assign limit_now[4]   = 1'b0;
    assign limit_now[3]   = limit_sync2_reg[0];
    assign limit_now[2:0] = 3'h0;

    // Page translation and decode
    always_comb
    begin
        is_page_control = (acc_offset == page_status_pkg::ADDR_PAGE_CONTROL_0[7:0]) ||
                          (acc_offset == page_status_pkg::ADDR_PAGE_CONTROL_1[7:0]);
        addr_next       = {1'b0, acc_offset};
        hit_next        = 1'b0;
        rdata_next      = 8'h00;
        if (is_page_control)
        begin
            addr_next  = {1'b0, acc_offset};
            hit_next   = 1'b1;
            rdata_next = page_control_reg & page_status_pkg::PAGE_CONTROL_MASK;
        end
        else if (page_control_reg[2:0] == page_status_pkg::PAGE_0)
        begin
            addr_next = {2'b00, acc_offset[6:0]};
            hit_next  = (addr_next >= page_status_pkg::PAGE0_FIRST) &&
                        (addr_next <= page_status_pkg::PAGE0_LAST);
        end
        else if (page_control_reg[2:0] == page_status_pkg::PAGE_1)
        begin
            addr_next = {2'b01, acc_offset[6:0]};
            hit_next  = (addr_next >= page_status_pkg::PAGE1_FIRST) &&
                        (addr_next <= page_status_pkg::PAGE1_LAST);
        end
        else if (page_control_reg[2:0] == page_status_pkg::PAGE_2)
        begin
            addr_next = {2'b10, acc_offset[6:0]};
            hit_next  = (addr_next >= page_status_pkg::PAGE2_FIRST) &&
                        (addr_next <= page_status_pkg::PAGE2_LAST);
        end
        if (!is_page_control && hit_next)
        begin
            if (addr_next == page_status_pkg::ADDR_STATUS_MISC)
            begin
                rdata_next = misc_now;
            end
            else if (addr_next == page_status_pkg::ADDR_STATUS_LOW)
            begin
                rdata_next = low_now;
            end
            else if (addr_next == page_status_pkg::ADDR_STATUS_HIGH)
            begin
                rdata_next = high_now;
            end
            else if (addr_next == page_status_pkg::ADDR_STATUS_LIMITS)
            begin
                rdata_next = limit_now;
            end
        end
    end

    // Interface-private page control register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            page_control_reg <= page_status_pkg::PAGE_CONTROL_RESET;
        end
        else if (acc_valid && acc_write && is_page_control)
        begin
            page_control_reg <= acc_wdata & page_status_pkg::PAGE_CONTROL_MASK;
        end
        else if (acc_done && page_control_reg[page_status_pkg::AUTO_RETURN_BIT])
        begin
            page_control_reg[2:0] <= page_status_pkg::PAGE_0;
        end
    end

    // Registered answer to each access
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_rdata <= 8'h00;
            acc_hit   <= 1'b0;
            acc_addr  <= 9'h000;
        end
        else if (acc_valid)
        begin
            acc_rdata <= acc_write ? 8'h00 : rdata_next;
            acc_hit   <= hit_next;
            acc_addr  <= addr_next;
        end
    end

    assign page_select         = page_control_reg[2:0];
    assign repeated_write_mode = page_control_reg[page_status_pkg::WRITE_MODE_BIT];
endmodule : page_status_bank

// ---- bench/host_model.sv ----
// Host side model issuing byte accesses and end-of-transaction pulses
`timescale 1ns/1ns
module host_model
(
    // Clock from the bench
    input  wire logic       clk,
    // Byte access and stop strobes
    output logic            acc_valid,
    output logic            acc_write,
    output logic            acc_done,
    output logic      [7:0] acc_offset,
    output logic      [7:0] acc_wdata
);
    initial {acc_valid, acc_write, acc_done, acc_offset, acc_wdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] off, input logic [7:0] d);
        @(posedge clk);
        #1 {acc_valid, acc_write, acc_offset, acc_wdata} = {1'b1, w, off, d};
    endtask : xfer
    task automatic idle;
        @(posedge clk);
        #1 {acc_valid, acc_write, acc_offset, acc_wdata} = {2'b00, ~acc_offset, ~acc_wdata};
    endtask : idle
    task automatic stop;
        @(posedge clk);
        #1 acc_done = 1'b1;
        @(posedge clk);
        #1 acc_done = 1'b0;
    endtask : stop
endmodule : host_model

// ---- bench/page_status_bank_asserts.sv ----
// Checker for the page control and status bank
`timescale 1ns/1ns
module page_status_bank_asserts
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Access port
    input wire logic       acc_valid,
    input wire logic       acc_write,
    input wire logic       acc_done,
    input wire logic [7:0] acc_offset,
    input wire logic [7:0] acc_wdata,
    // Answer and page state
    input wire logic [7:0] acc_rdata,
    input wire logic       acc_hit,
    input wire logic [8:0] acc_addr,
    input wire logic [2:0] page_select,
    input wire logic       repeated_write_mode
);
    logic auto_q, pcw, rd, win;
    logic [8:0] xa;
    assign pcw = acc_valid && acc_write && acc_offset[6:0] == 7'h00;
    assign rd  = acc_valid && !acc_write && page_select == 3'h0;
    assign xa  = {page_select[1:0], acc_offset[6:0]};
    assign win = page_select == 3'h1 ? acc_offset[6:0] <= 7'h4F
               : page_select[2] == 1'b0 && page_select != 3'h3 && acc_offset[6:0] <= 7'h3F;
    always_ff @(posedge clk)
        if (!rst_n) auto_q <= 1'b0;
        else if (pcw) auto_q <= acc_wdata[7];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_wr;
        pcw |=> page_select == $past(acc_wdata[2:0]) &&
                repeated_write_mode == $past(acc_wdata[6]);
    endproperty
    a_wr: assert property (p_wr) else $error("page write");
    property p_done;
        acc_done && !pcw |=> page_select == (auto_q ? 3'h0 : $past(page_select));
    endproperty
    a_done: assert property (p_done) else $error("auto return");
    property p_pcrd;
        acc_valid && !acc_write && acc_offset[6:0] == 7'h00
        |=> acc_hit && acc_rdata == {auto_q, repeated_write_mode, 3'h0, $past(page_select)};
    endproperty
    a_pcrd: assert property (p_pcrd) else $error("page read");
    property p_win;
        acc_valid && acc_offset[6:0] != 7'h00
        |=> acc_hit == $past(win) && (!acc_hit || acc_addr == $past(xa));
    endproperty
    a_win: assert property (p_win) else $error("window");
    property p_ro;
        acc_valid && acc_write && !pcw && !acc_done
        |=> acc_rdata == 8'h00 && $stable(page_select);
    endproperty
    a_ro: assert property (p_ro) else $error("write ignored");
    property p_misc;
        rd && acc_offset == 8'h01
        |=> acc_hit && acc_addr == 9'h001 && acc_rdata[7:4] == 4'h0;
    endproperty
    a_misc: assert property (p_misc) else $error("misc status");
    property p_lim;
        rd && acc_offset == 8'h04 |=> {acc_rdata[4], acc_rdata[2:0]} == 4'h0;
    endproperty
    a_lim: assert property (p_lim) else $error("limit status");
    property p_hold;
        !acc_valid && !acc_done |=> $stable(acc_rdata) && $stable(page_select);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    c_auto: cover property (acc_done && auto_q);
    c_page2: cover property (acc_hit && acc_addr[8]);
    c_test: cover property (acc_valid && page_select == 3'h3);
endmodule : page_status_bank_asserts
bind page_status_bank page_status_bank_asserts chk
(
    .clk                 (clk),
    .rst_n               (rst_n),
    .acc_valid           (acc_valid),
    .acc_write           (acc_write),
    .acc_done            (acc_done),
    .acc_offset          (acc_offset),
    .acc_wdata           (acc_wdata),
    .acc_rdata           (acc_rdata),
    .acc_hit             (acc_hit),
    .acc_addr            (acc_addr),
    .page_select         (page_select),
    .repeated_write_mode (repeated_write_mode)
);

// ---- bench/tb_top.sv ----
// Testbench for the page control and status bank
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [3:0]  misc;
        logic [15:0] gi;
        logic [2:0]  mode, hi;
        logic [3:0]  oc;
        logic [7:0]  off, exp;
    } row_t;
    logic clk = 1'b0, rst_n = 1'b0;
    logic acc_valid, acc_write, acc_done, acc_hit, repeated_write_mode;
    logic [7:0] acc_offset, acc_wdata, acc_rdata;
    logic [8:0] acc_addr;
    logic [2:0] page_select;
    row_t pins = '0;
    int err_count = 0, compares = 0, cycles = 0;
    row_t rows [6] = '{'{4'hA, 16'h0000, 3'h0, 3'h0, 4'h0, 8'h01, 8'h0B},
        '{4'h5, 16'h0000, 3'h0, 3'h0, 4'h0, 8'h01, 8'h04},
        '{4'h1, 16'h5AC3, 3'h5, 3'h2, 4'h0, 8'h02, 8'hC2},
        '{4'h1, 16'h5A00, 3'h7, 3'h7, 4'h0, 8'h02, 8'h07},
        '{4'h1, 16'h5A00, 3'h7, 3'h7, 4'h0, 8'h03, 8'h5A},
        '{4'h1, 16'h5A00, 3'h0, 3'h0, 4'hF, 8'h04, 8'hE8}};
    host_model host
    (
        .clk        (clk),
        .acc_valid  (acc_valid),
        .acc_write  (acc_write),
        .acc_done   (acc_done),
        .acc_offset (acc_offset),
        .acc_wdata  (acc_wdata)
    );
    page_status_bank DUT
    (
        .clk                 (clk),
        .rst_n               (rst_n),
        .acc_valid           (acc_valid),
        .acc_write           (acc_write),
        .acc_offset          (acc_offset),
        .acc_wdata           (acc_wdata),
        .acc_done            (acc_done),
        .acc_rdata           (acc_rdata),
        .acc_hit             (acc_hit),
        .acc_addr            (acc_addr),
        .page_select         (page_select),
        .repeated_write_mode (repeated_write_mode),
        .comparator_1v2_out  (pins.misc[3]),
        .voltage_ramp_active (pins.misc[2]),
        .charger_wake_pin    (pins.misc[1]),
        .power_key_n         (pins.misc[0]),
        .general_input       (pins.gi),
        .adc_mode            (pins.mode),
        .adc_above_high      (pins.hi),
        .reg11_overcurrent   (pins.oc[3]),
        .reg8_overcurrent    (pins.oc[2]),
        .reg7_overcurrent    (pins.oc[1]),
        .reg3_overcurrent    (pins.oc[0])
    );
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] off, input logic [7:0] d);
        host.xfer(w, off, d);
        host.idle();
    endtask : acc
    task automatic final_report;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        acc(1'b0, 8'h80, 8'h00);
        check({acc_hit, acc_rdata}, 9'h100);
        foreach (rows[i])
        begin
            pins = rows[i];
            repeat (4) @(posedge clk);
            acc(1'b0, rows[i].off, 8'h00);
            check({acc_hit, acc_rdata}, {1'b1, rows[i].exp});
        end
        acc(1'b1, 8'h80, 8'hFA);
        check({repeated_write_mode, 5'h0, page_select}, 9'h102);
        acc(1'b0, 8'h00, 8'h00);
        check({acc_hit, acc_rdata}, 9'h1C2);
        acc(1'b0, 8'h01, 8'h00);
        check(acc_addr, 9'h101);
        acc(1'b0, 8'h40, 8'h00);
        check({acc_hit, acc_rdata}, 9'h000);
        host.stop();
        check({repeated_write_mode, 5'h0, page_select}, 9'h100);
        acc(1'b1, 8'h00, 8'h01);
        host.stop();
        check({repeated_write_mode, 5'h0, page_select}, 9'h001);
        acc(1'b0, 8'h4F, 8'h00);
        check(acc_addr, 9'h0CF);
        acc(1'b1, 8'h00, 8'h00);
        acc(1'b1, 8'h04, 8'h00);
        acc(1'b0, 8'h04, 8'h00);
        check({acc_hit, acc_rdata}, 9'h1E8);
        host.xfer(1'b1, 8'h80, 8'h03);
        acc(1'b0, 8'h01, 8'h00);
        check({acc_hit, acc_rdata}, 9'h000);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check({repeated_write_mode, 5'h0, page_select}, 9'h000);
        final_report();
    end
endmodule : tb_top
